// ### rtl/acai_pkg.sv
// Shared constants for the amplifier control and audio input ends.
package acai_pkg;
  localparam int MCLK_HZ = 200_000_000;
  localparam int I2C_MAX_HZ = 400_000;
  localparam int I2C_QTR_CYC = (MCLK_HZ + 4 * I2C_MAX_HZ - 1) / (4 * I2C_MAX_HZ);
  localparam int FS_MIN_HZ = 44_100;
  localparam int FS_MAX_HZ = 96_000;
  localparam logic [12:0] FRAME_TOL = 13'h040;
  localparam logic [12:0] FRAME_MAX_CYC = 13'(MCLK_HZ / FS_MIN_HZ) + FRAME_TOL;
  localparam logic [12:0] FRAME_MIN_CYC = 13'(MCLK_HZ / FS_MAX_HZ) - FRAME_TOL;
  localparam logic [12:0] FSW_MULT = 13'h02c;
  localparam logic [9:0] SLOT_BITS = 10'h020;
  localparam logic [4:0] ADDR_BASE_DEF = 5'h0e;
  // Device register offsets and the audio port reset value.
  localparam logic [7:0] REG_AUDIO_PORT = 8'h03;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_FAULT = 8'h10;
  localparam logic [7:0] REG_MISC3 = 8'h21;
  localparam logic [7:0] AUDIO_PORT_RST = 8'h04;
  // Field positions.
  localparam int APC_FMT_HI = 7;
  localparam int APC_FMT_LO = 6;
  localparam int APC_SLOT_HI = 5;
  localparam int APC_SLOT_LO = 3;
  localparam int APC_WID_HI = 2;
  localparam int APC_WID_LO = 0;
  localparam int MISC3_CLR = 7;
  localparam int MISC3_FSEL = 6;
  localparam int MISC3_PARALLEL_BRIDGE_MODE = 0;
  localparam int FLT_CLOCK = 0;
  localparam int FLT_PARALLEL_BRIDGE_MODE = 1;
  localparam int STATE_PARALLEL_BRIDGE_MODE = 4;
  // Framing and channel state codes.
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_RJ = 2'h2;
  localparam logic [1:0] FMT_TDM = 2'h3;
  localparam logic [1:0] ST_STANDBY = 2'h0;
  localparam logic [1:0] ST_MUTE = 2'h1;
  localparam logic [1:0] ST_PLAY = 2'h2;
  // Controller register offsets.
  localparam logic [7:0] HREG_TARGET = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h01;
  localparam logic [7:0] HREG_CTRL = 8'h02;
  localparam logic [7:0] HREG_STATUS = 8'h03;
  localparam logic [7:0] HREG_RDATA = 8'h04;
  localparam logic [7:0] HREG_SLAVE = 8'h05;

  // Word width in bits for a width code.
  function automatic logic [5:0] acai_width(input logic [2:0] code);
    case (code)
      3'h0: return 6'h10;
      3'h1: return 6'h12;
      3'h2: return 6'h14;
      3'h3: return 6'h18;
      default: return 6'h20;
    endcase
  endfunction : acai_width
endpackage : acai_pkg

// ### rtl/acai_link_if.sv
// Open-drain two-wire control link between controller and amplifier.
`timescale 1ns/10ps
`default_nettype none
interface acai_link_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND of the open-drain drivers with a pull-up.
  assign scl = ~(host_scl_oe & ~host_scl_out);
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));
  modport host (output host_scl_out, output host_scl_oe, output host_sda_out,
    output host_sda_oe, input scl, input sda);
  modport device (output dev_sda_out, output dev_sda_oe, input scl, input sda);
endinterface : acai_link_if
`default_nettype wire

// ### rtl/acai_device_end.sv
// Amplifier end: two-wire slave, registers, faults and serial audio receiver.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module acai_device_end #(
  parameter logic [4:0] ADDR_BASE = acai_pkg::ADDR_BASE_DEF
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Control link and address strap
  acai_link_if.device link,
  input wire logic [1:0] addr_strap,
  // Serial audio pins
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic sdin,
  // Received audio, switching tick and channel play flags
  output logic [31:0] left_sample,
  output logic [31:0] right_sample,
  output logic sample_valid,
  output logic pwm_tick,
  output logic [1:0] ch_playing
);
  import acai_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_REG, S_WDATA, S_ACK, S_RDATA, S_RACK} acai_sst_t;

  logic [4:0] sync1, sync2, prev;
  logic [1:0] strap;
  logic strap_taken;
  acai_sst_t sst, after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, ptr;
  logic [7:0] audio_port_control;
  logic [6:0] misc_control_three;
  logic [3:0] state_ctl;
  logic parallel_bridge_mode_active;
  logic [1:0] fault_latch;
  logic [12:0] cyc_cnt, frame_len, acc;
  logic [31:0] shift, left_raw;
  logic lr_q;
  logic [9:0] cnt;

  // Pins from outside the clock domain pass two flops first.
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
      prev <= 5'h1f;
    end
    else if (clk_en)
    begin
      sync1 <= {link.scl, link.sda, bclk, lrclk, sdin};
      sync2 <= sync1;
      prev <= sync2;
    end

  wire scl_s = sync2[4];
  wire sda_s = sync2[3];
  wire bclk_s = sync2[2];
  wire lr_s = sync2[1];
  wire din_s = sync2[0];
  wire scl_rise = scl_s & ~prev[4];
  wire scl_fall = ~scl_s & prev[4];
  wire start_c = scl_s & prev[4] & ~sda_s & prev[3];
  wire stop_c = scl_s & prev[4] & sda_s & ~prev[3];
  wire bclk_rise = bclk_s & ~prev[2];
  wire lr_rise_m = lr_s & ~prev[1];

  // Strap is caught once after reset release.
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      strap <= 2'h0;
      strap_taken <= 1'b0;
    end
    else if (clk_en && !strap_taken)
    begin
      strap <= addr_strap;
      strap_taken <= 1'b1;
    end

  wire addr_hit = strap_taken && shreg[7:1] == {ADDR_BASE, strap};
  wire byte_end = scl_fall && bit_cnt == 4'h8;
  wire wr_fire = sst == S_WDATA && byte_end;
  wire [1:0] st1 = state_ctl[1:0];
  wire [1:0] st2 = state_ctl[3:2];
  wire fault_clr = wr_fire && ptr == REG_MISC3 && shreg[MISC3_CLR];

  // Register read selection.
  wire [7:0] rd_val = (ptr == REG_AUDIO_PORT) ? audio_port_control :
    (ptr == REG_STATE) ? {3'h0, parallel_bridge_mode_active, state_ctl} :
    (ptr == REG_FAULT) ? {6'h00, fault_latch} :
    (ptr == REG_MISC3) ? {1'b0, misc_control_three} : 8'h00;

  // Slave only: the clock line is never driven and nothing starts a transfer.
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      sst <= S_IDLE;
      after_ack <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      link.dev_sda_oe <= 1'b0;
      link.dev_sda_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start_c)
      begin
        sst <= S_ADDR;
        bit_cnt <= 4'h0;
        link.dev_sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        sst <= S_IDLE;
        link.dev_sda_oe <= 1'b0;
      end
      else
        case (sst)
          S_ADDR, S_REG, S_WDATA:
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (byte_end)
            begin
              bit_cnt <= 4'h0;
              link.dev_sda_oe <= sst != S_ADDR || addr_hit;
              sst <= (sst == S_ADDR && !addr_hit) ? S_IDLE : S_ACK;
              if (sst == S_ADDR)
                after_ack <= shreg[0] ? S_RDATA : S_REG;
              else
                after_ack <= S_WDATA;
              if (sst == S_REG)
                ptr <= shreg;
              else if (sst == S_WDATA)
                ptr <= ptr + 8'h01;
            end
          S_ACK:
            if (scl_fall)
            begin
              sst <= after_ack;
              if (after_ack == S_RDATA)
              begin
                link.dev_sda_oe <= ~rd_val[7];
                shreg <= {rd_val[6:0], 1'b0};
                bit_cnt <= 4'h1;
              end
              else
                link.dev_sda_oe <= 1'b0;
            end
          S_RDATA:
            if (byte_end)
            begin
              link.dev_sda_oe <= 1'b0;
              ptr <= ptr + 8'h01;
              sst <= S_RACK;
            end
            else if (scl_fall)
            begin
              link.dev_sda_oe <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          S_RACK:
            if (scl_rise)
            begin
              sst <= sda_s ? S_IDLE : S_ACK;
              after_ack <= S_RDATA;
            end
          default:
            sst <= S_IDLE;
        endcase
    end

  // Configuration registers and fault latches.
  wire parallel_bridge_mode_mismatch = parallel_bridge_mode_active && st1 != st2;
  wire clk_fault = cyc_cnt > FRAME_MAX_CYC || frame_len < FRAME_MIN_CYC ||
    frame_len > FRAME_MAX_CYC;
  wire [1:0] fault_live = {parallel_bridge_mode_mismatch, clk_fault};

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      audio_port_control <= AUDIO_PORT_RST;
      misc_control_three <= 7'h00;
      state_ctl <= {ST_STANDBY, ST_STANDBY};
      parallel_bridge_mode_active <= 1'b0;
      fault_latch <= 2'h0;
    end
    else if (clk_en)
    begin
      if (wr_fire && ptr == REG_AUDIO_PORT)
        audio_port_control <= shreg;
      if (wr_fire && ptr == REG_MISC3)
        misc_control_three <= shreg[6:0];
      if (wr_fire && ptr == REG_STATE)
        state_ctl <= shreg[3:0];
      if (st1 == ST_STANDBY && st2 == ST_STANDBY)
        parallel_bridge_mode_active <= misc_control_three[MISC3_PARALLEL_BRIDGE_MODE];
      fault_latch <= (fault_latch & ~{2{fault_clr}}) | fault_live;
    end

  // Frame length measurement against the allowed rates and the switching tick.
  wire [12:0] acc_sum = acc + FSW_MULT;
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      cyc_cnt <= 13'h0000;
      frame_len <= 13'h0000;
      acc <= 13'h0000;
      pwm_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      if (lr_rise_m)
      begin
        frame_len <= cyc_cnt;
        cyc_cnt <= 13'h0001;
      end
      else if (cyc_cnt != 13'h1fff)
        cyc_cnt <= cyc_cnt + 13'h0001;
      if (clk_fault)
      begin
        acc <= 13'h0000;
        pwm_tick <= 1'b0;
      end
      else if (acc_sum >= frame_len)
      begin
        acc <= acc_sum - frame_len;
        pwm_tick <= 1'b1;
      end
      else
      begin
        acc <= acc_sum;
        pwm_tick <= 1'b0;
      end
    end

  // Serial audio capture.
  wire [1:0] fmt = audio_port_control[APC_FMT_HI:APC_FMT_LO];
  wire [2:0] slot = audio_port_control[APC_SLOT_HI:APC_SLOT_LO];
  wire [5:0] wid = acai_width(audio_port_control[APC_WID_HI:APC_WID_LO]);
  wire tdm = fmt == FMT_TDM;
  wire rj = fmt == FMT_RJ;
  wire lr_chg = lr_s != lr_q;
  wire restart = tdm ? (lr_s & ~lr_q) : lr_chg;
  wire [9:0] idx = restart ? 10'h000 : cnt;
  wire [9:0] base_t = tdm ? {1'b0, slot, 6'h00} : 10'h000;
  wire [9:0] tgt_l = base_t + {4'h0, wid} - ((fmt == FMT_LJ) ? 10'h001 : 10'h000);
  wire [9:0] tgt_r = tgt_l + SLOT_BITS;
  // The bit position is counted before any restart, so a word whose last bit falls on the
  // word clock edge is still caught, and it belongs to the half that has just ended.
  wire hit_std = !rj && !tdm && cnt == tgt_l;
  wire left_std = (fmt == FMT_I2S) ? ~lr_q : lr_q;
  wire cap_left = bclk_rise && ((hit_std && left_std) || (rj && lr_chg && lr_q) ||
    (tdm && cnt == tgt_l));
  wire cap_right = bclk_rise && ((hit_std && !left_std) || (rj && lr_chg && !lr_q) ||
    (tdm && cnt == tgt_r));
  wire [31:0] raw = rj ? shift : {shift[30:0], din_s};
  wire [31:0] aligned = raw << (6'h20 - wid);
  wire [31:0] pick = misc_control_three[MISC3_FSEL] ? aligned : left_raw;
  wire [31:0] next_left = parallel_bridge_mode_active ? pick : left_raw;
  wire [31:0] next_right = parallel_bridge_mode_active ? pick : aligned;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      shift <= 32'h00000000;
      lr_q <= 1'b0;
      cnt <= 10'h000;
      left_raw <= 32'h00000000;
      left_sample <= 32'h00000000;
      right_sample <= 32'h00000000;
      sample_valid <= 1'b0;
      ch_playing <= 2'h0;
    end
    else if (clk_en)
    begin
      ch_playing <= {st2 == ST_PLAY, st1 == ST_PLAY};
      sample_valid <= cap_right;
      if (bclk_rise)
      begin
        shift <= {shift[30:0], din_s};
        lr_q <= lr_s;
        cnt <= (idx == 10'h3ff) ? idx : idx + 10'h001;
      end
      if (cap_left)
        left_raw <= aligned;
      if (cap_right)
      begin
        left_sample <= (st1 == ST_PLAY) ? next_left : 32'h00000000;
        right_sample <= (st2 == ST_PLAY) ? next_right : 32'h00000000;
      end
    end
endmodule : acai_device_end
`default_nettype wire

// ### rtl/acai_host_end.sv
// Controller end: two-wire master driven through a small register port.
`timescale 1ns/10ps
`default_nettype none
module acai_host_end #(
  parameter logic [6:0] SLAVE_DEF = {acai_pkg::ADDR_BASE_DEF, 2'h0}
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Control link
  acai_link_if.host link
);
  import acai_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} acai_mst_t;

  acai_mst_t mst;
  logic [7:0] target, wdata, rdata, rx_sh;
  logic [6:0] slave;
  logic sda1, sda2;
  logic busy, nack, refused, is_read, ack_q, clr_sent, fault_ok;
  logic [7:0] qcnt;
  logic [1:0] q, byte_idx;
  logic [3:0] bit_idx;

  wire tick = qcnt == 8'(I2C_QTR_CYC - 1);
  wire rx_byte = is_read && byte_idx == 2'h3;
  wire [7:0] tx_byte = (byte_idx == 2'h0) ? {slave, 1'b0} :
    (byte_idx == 2'h1) ? target :
    is_read ? {slave, 1'b1} : wdata;
  wire tx_bit = tx_byte[3'(4'h7 - bit_idx)];
  wire ctrl_wr = reg_wr && reg_addr == HREG_CTRL && !busy;
  wire play_req = target == REG_STATE && (wdata[1:0] == ST_PLAY || wdata[3:2] == ST_PLAY);
  wire go_wr = ctrl_wr && reg_wdata[0] && !(play_req && !fault_ok);
  wire go_rd = ctrl_wr && reg_wdata[1] && !reg_wdata[0];
  wire last_tx = byte_idx == 2'h2 && !is_read;
  wire [7:0] status = {4'h0, fault_ok, refused, nack, busy};

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      sda1 <= 1'b1;
      sda2 <= 1'b1;
      reg_rdata <= 8'h00;
      target <= 8'h00;
      wdata <= 8'h00;
      slave <= SLAVE_DEF;
    end
    else if (clk_en)
    begin
      sda1 <= link.sda;
      sda2 <= sda1;
      if (reg_wr && reg_addr == HREG_TARGET)
        target <= reg_wdata;
      if (reg_wr && reg_addr == HREG_WDATA)
        wdata <= reg_wdata;
      if (reg_wr && reg_addr == HREG_SLAVE)
        slave <= reg_wdata[6:0];
      if (!reg_rd)
        reg_rdata <= 8'h00;
      else if (reg_addr == HREG_TARGET)
        reg_rdata <= target;
      else if (reg_addr == HREG_WDATA)
        reg_rdata <= wdata;
      else if (reg_addr == HREG_STATUS)
        reg_rdata <= status;
      else if (reg_addr == HREG_RDATA)
        reg_rdata <= rdata;
      else if (reg_addr == HREG_SLAVE)
        reg_rdata <= {1'b0, slave};
      else
        reg_rdata <= 8'h00;
    end

  // Master sequencer; each bit is four quarter periods of the link clock.
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      mst <= M_IDLE;
      qcnt <= 8'h00;
      q <= 2'h0;
      byte_idx <= 2'h0;
      bit_idx <= 4'h0;
      rx_sh <= 8'h00;
      rdata <= 8'h00;
      busy <= 1'b0;
      nack <= 1'b0;
      refused <= 1'b0;
      is_read <= 1'b0;
      ack_q <= 1'b0;
      clr_sent <= 1'b0;
      fault_ok <= 1'b0;
      link.host_scl_oe <= 1'b0;
      link.host_sda_oe <= 1'b0;
      link.host_scl_out <= 1'b0;
      link.host_sda_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (mst == M_IDLE)
      begin
        qcnt <= 8'h00;
        q <= 2'h0;
        if (ctrl_wr)
          refused <= reg_wdata[0] && !go_wr;
        if (go_wr || go_rd)
        begin
          mst <= M_START;
          busy <= 1'b1;
          nack <= 1'b0;
          is_read <= go_rd;
          byte_idx <= 2'h0;
        end
      end
      else
      begin
        qcnt <= tick ? 8'h00 : qcnt + 8'h01;
        if (tick)
        begin
          q <= q + 2'h1;
          case (mst)
            M_START:
              case (q)
                2'h0: link.host_sda_oe <= 1'b0;
                2'h1: link.host_scl_oe <= 1'b0;
                2'h2: link.host_sda_oe <= 1'b1;
                default:
                begin
                  link.host_scl_oe <= 1'b1;
                  bit_idx <= 4'h0;
                  mst <= M_BIT;
                end
              endcase
            M_BIT:
              case (q)
                2'h0: link.host_sda_oe <= bit_idx < 4'h8 && !rx_byte && !tx_bit;
                2'h1: link.host_scl_oe <= 1'b0;
                2'h2:
                  if (bit_idx < 4'h8)
                    rx_sh <= {rx_sh[6:0], sda2};
                  else
                    ack_q <= ~sda2;
                default:
                begin
                  link.host_scl_oe <= 1'b1;
                  bit_idx <= bit_idx + 4'h1;
                  if (bit_idx == 4'h8)
                  begin
                    bit_idx <= 4'h0;
                    byte_idx <= byte_idx + 2'h1;
                    if (rx_byte)
                    begin
                      rdata <= rx_sh;
                      mst <= M_STOP;
                    end
                    else if (!ack_q || last_tx)
                    begin
                      nack <= !ack_q;
                      mst <= M_STOP;
                    end
                    else if (is_read && byte_idx == 2'h1)
                      mst <= M_START;
                  end
                end
              endcase
            default:
              case (q)
                2'h0: link.host_sda_oe <= 1'b1;
                2'h1: link.host_scl_oe <= 1'b0;
                2'h2: link.host_sda_oe <= 1'b0;
                default:
                begin
                  mst <= M_IDLE;
                  busy <= 1'b0;
                  if (!nack && !is_read && target == REG_MISC3 && wdata[MISC3_CLR])
                  begin
                    clr_sent <= 1'b1;
                    fault_ok <= 1'b0;
                  end
                  else if (!nack && !is_read && target != REG_STATE)
                  begin
                    clr_sent <= 1'b0;
                    fault_ok <= 1'b0;
                  end
                  else if (!nack && is_read && target == REG_FAULT)
                    fault_ok <= clr_sent && rx_sh == 8'h00;
                end
              endcase
          endcase
        end
      end
    end
endmodule : acai_host_end
`default_nettype wire

// ### verification/acai_link_asserts.sv
// Concurrent checks on the two-wire link between the controller and amplifier ends.
`timescale 1ns/10ps
`default_nettype none
module acai_link_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link signals
  input wire logic host_scl_out,
  input wire logic host_scl_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [12:0] hi_cnt;
  logic [12:0] lo_cnt;
  logic [12:0] dev_cnt;

  // Saturating counts of clock high, clock low and device drive time.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hi_cnt <= 13'h0;
      lo_cnt <= 13'h0;
      dev_cnt <= 13'h0;
    end
    else
    begin
      hi_cnt <= scl ? hi_cnt + {12'h0, ~&hi_cnt} : 13'h0;
      lo_cnt <= scl ? 13'h0 : lo_cnt + {12'h0, ~&lo_cnt};
      dev_cnt <= dev_sda_oe ? dev_cnt + {12'h0, ~&dev_cnt} : 13'h0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence start_s;
    scl && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $rose(sda);
  endsequence

  rst_release_a: assert property ($fell(sys_rst) |-> !dev_sda_oe && !host_scl_oe
    && !host_sda_oe && scl && sda) else $error("link not idle after reset");
  open_drain_a: assert property (!dev_sda_out && !host_sda_out && !host_scl_out)
    else $error("open-drain data value not low");
  scl_high_a: assert property ($fell(scl) |-> hi_cnt >= 13'd245)
    else $error("clock high phase too short");
  scl_low_a: assert property ($rose(scl) |-> lo_cnt >= 13'd245)
    else $error("clock low phase too short");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  start_quiet_a: assert property (start_s |=> !dev_sda_oe [*8])
    else $error("device drove data right after start");
  stop_quiet_a: assert property (stop_s |=> !dev_sda_oe [*8])
    else $error("device drove data right after stop");
  dev_hold_a: assert property (dev_sda_oe |-> dev_cnt < 13'd4600)
    else $error("device held data line too long");
endmodule : acai_link_asserts
`default_nettype wire

// ### verification/amp_control_and_audio_input_bench.sv
// Bench joining controller and amplifier ends, with serial audio stimulus.
`timescale 1ns/10ps
`default_nettype none
module amp_control_and_audio_input_bench;
  import acai_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic bclk = 1'b0;
  logic lrclk = 1'b0;
  logic sdin = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [31:0] left_sample;
  logic [31:0] right_sample;
  logic sample_valid;
  logic pwm_tick;
  logic [1:0] ch_playing;
  logic [5:0] bit_idx = 6'h0;
  logic [63:0] shreg = 64'h0;
  logic [63:0] nxt_fr = 64'h0;
  logic [63:0] cur_fr = 64'h0;
  logic [63:0] done_fr = 64'h0;
  logic [7:0] tick_cnt = 8'h0;
  logic [7:0] last_ticks = 8'h0;
  logic [7:0] rv = 8'h0;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  acai_link_if lnk ();
  acai_host_end i_acai_host_end (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link(lnk.host));
  acai_device_end i_acai_device_end (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .link(lnk.device), .addr_strap(strap), .bclk(bclk), .lrclk(lrclk), .sdin(sdin),
    .left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid),
    .pwm_tick(pwm_tick), .ch_playing(ch_playing));
  acai_link_asserts i_acai_link_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .host_scl_out(lnk.host_scl_out), .host_scl_oe(lnk.host_scl_oe),
    .host_sda_out(lnk.host_sda_out), .host_sda_oe(lnk.host_sda_oe),
    .dev_sda_out(lnk.dev_sda_out), .dev_sda_oe(lnk.dev_sda_oe),
    .scl(lnk.scl), .sda(lnk.sda));

  always #2.5 mclk = ~mclk;
  initial
  begin
    #1.3;
    forever #80 bclk = ~bclk;
  end

  // Two-channel framing, 32-bit words, data one bit clock after the word clock edge.
  always @(negedge bclk)
  begin
    bit_idx <= bit_idx + 6'h1;
    lrclk <= bit_idx[5];
    sdin <= shreg[63];
    shreg <= (bit_idx == 6'h0) ? nxt_fr : {shreg[62:0], 1'b0};
    if (bit_idx == 6'h0)
    begin
      nxt_fr <= {$urandom, $urandom};
      cur_fr <= nxt_fr;
      done_fr <= cur_fr;
    end
  end

  always @(posedge mclk)
  begin
    tick_cnt <= sample_valid ? 8'h0 : tick_cnt + {7'h0, pwm_tick};
    if (sample_valid)
    begin
      last_ticks <= tick_cnt + {7'h0, pwm_tick};
    end
    cyc <= cyc + 1;
    if (cyc == 100000)
    begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Start one link transfer and poll status until the controller is idle.
  task automatic xfer(input logic [7:0] tgt, input logic [7:0] d, input logic [7:0] ctl);
    int n;
    wr(HREG_TARGET, tgt);
    wr(HREG_WDATA, d);
    wr(HREG_CTRL, ctl);
    n = 0;
    rv = 8'h01;
    while (rv[0] === 1'b1 && n < 30000)
    begin
      rd(HREG_STATUS, rv);
      n++;
    end
    if (n >= 30000)
      fails++;
  endtask : xfer

  task automatic wait_valid();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (sample_valid !== 1'b1 && n < 5000);
    if (sample_valid !== 1'b1)
      fails++;
    #1;
  endtask : wait_valid

  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  initial
  begin
    void'($urandom(32'h8443));
    repeat (2) @(posedge mclk);
    strap <= 2'($urandom);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(HREG_STATUS, rv);
    chk("status", 32'h0, 32'(rv));
    rd(8'h07, rv);
    chk("unmapped", 32'h0, 32'(rv));
    wr(HREG_SLAVE, {1'b0, ADDR_BASE_DEF, strap});
    xfer(REG_STATE, 8'h0a, 8'h01);
    chk("refused", 32'h4, 32'(rv & 8'h07));
    xfer(REG_AUDIO_PORT, 8'h00, 8'h02);
    rd(HREG_RDATA, rv);
    chk("port reset", 32'(AUDIO_PORT_RST), 32'(rv));
    wr(HREG_SLAVE, {1'b0, ADDR_BASE_DEF, ~strap});
    xfer(REG_AUDIO_PORT, 8'h04, 8'h01);
    chk("nack", 32'h1, 32'(rv[1]));
    wr(HREG_SLAVE, {1'b0, ADDR_BASE_DEF, strap});
    xfer(REG_AUDIO_PORT, {FMT_I2S, 3'($urandom), 3'h4}, 8'h01);
    xfer(REG_MISC3, 8'h80, 8'h01);
    xfer(REG_FAULT, 8'h00, 8'h02);
    chk("fault gate", 32'h8, 32'(rv & 8'h0b));
    rd(HREG_RDATA, rv);
    chk("faults", 32'h0, 32'(rv));
    wait_valid();
    chk("muted left", 32'h0, left_sample);
    xfer(REG_STATE, 8'h0a, 8'h01);
    chk("play", 32'h3, 32'(ch_playing));
    wait_valid();
    wait_valid();
    chk("left", done_fr[63:32], left_sample);
    chk("right", done_fr[31:0], right_sample);
    chk("ticks", 32'd44, 32'(last_ticks));
    give_verdict();
  end
endmodule : amp_control_and_audio_input_bench
`default_nettype wire
